// ==== bench/host_model.sv ====
// host side model: receives indication bytes and keeps the last one
`default_nettype none
module host_model
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [7:0] host_tx_data,
	input  wire logic       host_tx_valid,
	output var  logic [7:0] last,
	output var  logic [7:0] cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	// a host that never stalls, so every byte is counted
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			cnt <= 8'h00;
		else if (host_tx_valid)
			cnt <= cnt + 8'h01;
	end
	always_ff @(posedge clk)
	begin
		if (host_tx_valid)
			last <= host_tx_data;
	end
endmodule
`default_nettype wire

// ==== bench/host_service_link_control_tb.sv ====
// self-checking bench of the host service link control block
`default_nettype none
module host_service_link_control_tb;
	import link_ctl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, reset = 1, host_rx_valid = 0, bus_rx_valid = 0, bus_rx_is_ack = 0;
	logic addressed_frame = 0, normal_entered = 0, reg_wr = 0, reg_rd = 0;
	logic [7:0] host_rx_data = 0, bus_rx_data = 0, reg_wdata = 0, ev = 0, seen = 0, r = 8'h51;
	logic [3:0] reg_addr = 0, fd = 0;
	logic [7:0] host_tx_data, bus_tx_data, reg_rdata, m_last, m_cnt;
	logic host_tx_valid, bus_tx_valid, bus_tx_last, bus_ack_valid, device_reset, busy_mode;
	logic bus_monitor, bus_ack_busy, auto_ack_flag, bad = 0;
	int mismatches = 0, checks_done = 0, cyc = 0;
	always #20 clk = ~clk;
	host_service_link_control uut (.clk, .reset, .host_rx_data, .host_rx_valid,
		.host_rx_corrupt(bad), .host_tx_data, .host_tx_valid, .bus_rx_data, .bus_rx_valid,
		.bus_rx_is_ack, .bus_tx_data, .bus_tx_valid, .bus_tx_last, .tx_confirm_valid(ev[6]),
		.tx_confirm_ok(ev[7]), .tx_frame_bad(ev[1]), .poll_slot_collision(ev[0]),
		.tx_active(ev[2]), .tx_drive_dominant(ev[3]), .bus_read_recessive(ev[4]),
		.thermal_warning(ev[5]), .frame_done(fd[3]), .frame_parity_err(fd[2]),
		.frame_cksum_err(fd[1]), .frame_timing_err(fd[0]), .addressed_frame, .bus_ack_valid,
		.bus_ack_busy, .normal_entered, .device_reset, .auto_ack_flag, .busy_mode,
		.bus_monitor, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	host_model partner (.clk, .reset, .host_tx_data, .host_tx_valid, .last(m_last), .cnt(m_cnt));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic wrap_up;
		if (mismatches == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e, input string n);
		checks_done++;
		if (s !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic send(input logic [7:0] b);
		@(posedge clk);
		host_rx_data <= b;
		host_rx_valid <= 1;
		@(posedge clk);
		host_rx_valid <= 0;
	endtask
	task automatic bus(input logic [7:0] b, input logic a);
		@(posedge clk);
		bus_rx_data <= b;
		bus_rx_is_ack <= a;
		bus_rx_valid <= 1;
		@(posedge clk);
		bus_rx_valid <= 0;
	endtask
	// bounded wait for the next indication byte at the host
	task automatic hexp(input logic [7:0] e);
		for (int i = 0; i < 12 && m_cnt === seen; i++)
			tick;
		seen++;
		chk({m_cnt, m_last}, {seen, e}, "host byte");
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk);
		reg_rd <= 0;
		#1;
		chk(reg_rdata, e, "reg read");
	endtask
	task automatic pulse(input logic [7:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 0;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			mismatches++;
			wrap_up;
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge clk);
		reset <= 0;
		rd(REG_STATUS, 8'h07);
		rd(4'hc, 8'h00);
		@(posedge clk);
		reg_addr <= REG_CONTROL;
		reg_wdata <= CONTROL_RESET;
		reg_wr <= 1;
		@(posedge clk);
		reg_wr <= 0;
		normal_entered <= 1;
		@(posedge clk);
		normal_entered <= 0;
		hexp(IND_RESET);
		pulse(8'h3f);
		send(CMD_STATE);
		hexp(8'hef);
		send(CMD_STATE);
		hexp(8'h07);
		for (int z = 0; z < 2; z++)
		begin
			pulse({z[0], 7'h40});
			hexp({z[0], IND_CONFIRM_LO});
		end
		send(CMD_CONFIGURE);
		hexp(8'h01);
		send(8'h1f);
		hexp(8'h1d);
		@(posedge clk);
		fd <= 4'hb;
		@(posedge clk);
		fd <= 0;
		hexp(IND_FRAME_END);
		hexp({3'b011, IND_FSTAT_LO});
		for (int k = 0; k < 3; k++)
		begin
			r = lfsr(r);
			send(CMD_DATA_START);
			send(r);
			#1;
			chk({bus_tx_valid, bus_tx_last, bus_tx_data}, {2'b10, r}, "bus tx");
			r = lfsr(r);
			send(CMD_END_LO);
			send(r);
			#1;
			chk({bus_tx_valid, bus_tx_last, bus_tx_data}, {2'b11, r}, "bus end");
			r = lfsr(r);
			bus(r, 0);
			hexp(r);
		end
		send(8'h81);
		send(8'h55);
		#1;
		chk(bus_tx_valid, 0, "orphan cont");
		bad <= 1;
		send(CMD_STATE);
		bad <= 0;
		send(CMD_STATE);
		hexp(8'h57);
		bus(8'hcc, 1);
		repeat (4) tick;
		chk(m_cnt, seen, "ack dropped");
		send(CMD_SET_BUSY);
		@(posedge clk);
		addressed_frame <= 1;
		@(posedge clk);
		addressed_frame <= 0;
		#1;
		chk({busy_mode, bus_ack_valid}, 0, "busy off");
		send(CMD_SET_ADDR);
		repeat (3) send(r);
		hexp(8'h3d);
		send(CMD_SET_BUSY);
		@(posedge clk);
		addressed_frame <= 1;
		@(posedge clk);
		addressed_frame <= 0;
		#1;
		chk({auto_ack_flag, busy_mode, bus_ack_valid, bus_ack_busy}, 4'hf, "busy ack");
		send(CMD_ACKN);
		tick;
		chk(busy_mode, 0, "busy end");
		send(CMD_SET_BUSY);
		send(CMD_QUIT_BUSY);
		tick;
		chk(busy_mode, 0, "quit busy");
		send(CMD_BUSMON);
		bus(8'hcc, 1);
		hexp(8'hcc);
		send(8'h1f);
		hexp(8'h3d);
		chk(bus_monitor, 1, "monitor");
		send(CMD_RESET);
		#1;
		chk(device_reset, 1, "reset pulse");
		tick;
		chk(bus_monitor, 0, "monitor left");
		send(CMD_CONFIGURE);
		hexp(8'h01);
		wrap_up;
	end
endmodule
`default_nettype wire

// ==== design/cmd_decode.sv ====
// sorts a host control byte into service, length and purpose
`default_nettype none
module cmd_decode
	import link_ctl_pkg::*;
(
	input  wire logic [7:0] ctrl,
	output var  svc_t       svc,
	output var  logic [1:0] extra,
	output var  logic       transmit
);
	always_comb
	begin
		svc      = SVC_NONE;
		extra    = EXTRA_NONE;
		transmit = 1'b0;
		if (ctrl == CMD_RESET)          svc = SVC_RESET;
		else if (ctrl == CMD_STATE)     svc = SVC_STATE;
		else if (ctrl == CMD_SET_BUSY)  svc = SVC_SET_BUSY;
		else if (ctrl == CMD_QUIT_BUSY) svc = SVC_QUIT_BUSY;
		else if (ctrl == CMD_BUSMON)    svc = SVC_BUSMON;
		else if (ctrl >= CMD_OFFSET_LO && ctrl <= CMD_OFFSET_HI) svc = SVC_OFFSET;
		else if (ctrl == CMD_SYS_STATE) svc = SVC_SYS_STATE;
		else if (ctrl == CMD_STOP)      svc = SVC_STOP;
		else if (ctrl == CMD_EXIT_STOP) svc = SVC_EXIT_STOP;
		else if ((ctrl & MASK_OCT) == CMD_ACKN)      svc = SVC_ACKN;
		else if ((ctrl & MASK_OCT) == CMD_CONFIGURE) svc = SVC_CONFIGURE;
		else if ((ctrl & MASK_QUAD) == CMD_REG_RD)   svc = SVC_REG_RD;
		else if ((ctrl & MASK_QUAD) == CMD_REG_WR)
		begin
			svc   = SVC_REG_WR;
			extra = EXTRA_ONE;
		end
		else if (ctrl == CMD_SET_ADDR || ctrl == CMD_SET_REP ||
			((ctrl & MASK_TOP4) == CMD_POLL && ctrl <= CMD_POLL_HI))
		begin
			svc   = (ctrl == CMD_SET_ADDR) ? SVC_SET_ADDR :
				(ctrl == CMD_SET_REP) ? SVC_SET_REP : SVC_POLL;
			extra = EXTRA_THREE;
		end
		else if ((ctrl & MASK_TOP2) == CMD_TOP_CONT)
		begin
			svc      = (ctrl == CMD_DATA_START) ? SVC_DATA_START : SVC_DATA_CONT;
			extra    = EXTRA_ONE;
			transmit = 1'b1;
		end
		else if ((ctrl & MASK_TOP2) == CMD_TOP_END && ctrl >= CMD_END_LO)
		begin
			svc      = SVC_DATA_END;
			extra    = EXTRA_ONE;
			transmit = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== design/event_flag.sv ====
// sticky event flag, set wins over clear
`default_nettype none
module event_flag
(
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic soft_clear,
	input  wire logic set,
	input  wire logic clear,
	output var  logic flag
);
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			flag <= 1'b0;
		else if (set)
			flag <= 1'b1;
		else if (clear || soft_clear)
			flag <= 1'b0;
	end
endmodule
`default_nettype wire

// ==== design/host_service_link_control.sv ====
// host service layer: command sorting, indications and bus byte forwarding
// Behaviour
// RULE_01: a single-byte command is its control byte alone, nothing more expected
// RULE_02: bytes after a multi-byte control byte are handled by that control byte
// RULE_03: internal commands never start bus traffic; only transmit commands do
// RULE_04: received data frame headers reach the host as received, priority in bits 3:2
// RULE_05: transmit confirmation byte is z0001011, z high for positive
// RULE_06: state byte is collision, rx err, tx err, protocol err, thermal, then 111
// RULE_07: frame status byte is parity, checksum, timing error, 1, reserved, 011
// RULE_08: configuration byte is 0, busy, auto ack, auto poll, crc, marker, 01
// RULE_09: every data byte from the bus goes to the host unchanged
// RULE_10: acknowledge bytes reach the host only while monitoring, else dropped
// RULE_11: reset command returns to initial state; reset byte sent on entering normal
// RULE_12: slave collision flag set on collision during a polling slot
// RULE_13: receive error flag set on corrupted host bytes or bad control octet
// RULE_14: transmit error flag set when driving dominant but reading recessive
// RULE_15: protocol error flag set on a disallowed command sequence
// RULE_16: thermal flag set whenever a thermal warning is present
// RULE_17: busy plus auto ack answers addressed frames with a busy acknowledge
// RULE_18: set busy does nothing while auto ack is off
// RULE_19: busy mode ends at once on the host acknowledge request
// RULE_20: quit busy restores positive acknowledges; no effect unless busy with auto ack
// RULE_21: monitoring passes all bus bytes with no link layer filtering
// RULE_22: monitoring is left only through the reset command
// RULE_23: auto ack stays on until the reset command
// RULE_24: state error flags are cleared once reported to the host
`default_nettype none
module host_service_link_control
	import link_ctl_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [7:0] host_rx_data,
	input  wire logic       host_rx_valid,
	input  wire logic       host_rx_corrupt,
	output logic      [7:0] host_tx_data,
	output logic            host_tx_valid,
	input  wire logic [7:0] bus_rx_data,
	input  wire logic       bus_rx_valid,
	input  wire logic       bus_rx_is_ack,
	output logic      [7:0] bus_tx_data,
	output logic            bus_tx_valid,
	output logic            bus_tx_last,
	input  wire logic       tx_confirm_valid,
	input  wire logic       tx_confirm_ok,
	input  wire logic       tx_frame_bad,
	input  wire logic       poll_slot_collision,
	input  wire logic       tx_active,
	input  wire logic       tx_drive_dominant,
	input  wire logic       bus_read_recessive,
	input  wire logic       thermal_warning,
	input  wire logic       frame_done,
	input  wire logic       frame_parity_err,
	input  wire logic       frame_cksum_err,
	input  wire logic       frame_timing_err,
	input  wire logic       addressed_frame,
	output logic            bus_ack_valid,
	output logic            bus_ack_busy,
	input  wire logic       normal_entered,
	output logic            device_reset,
	output logic            auto_ack_flag,
	output logic            busy_mode,
	output logic            bus_monitor,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	parse_state_t state;
	svc_t         svc;
	svc_t         arg_kind;
	logic [1:0]   extra;
	logic [1:0]   args_left;
	logic         transmit;
	logic         arg_tx;
	logic [7:0]   control;
	logic         in_frame;
	logic         auto_poll_flag;
	logic         crc_flag;
	logic         marker_flag;
	logic         slave_collision_flag;
	logic         receive_error_flag;
	logic         transmit_error_flag;
	logic         protocol_error_flag;
	logic         thermal_warning_flag;
	logic         confirm_ok;
	logic [7:0]   fstat_byte;
	logic         pend_confirm;
	logic         pend_reset;
	logic         pend_state;
	logic         pend_config;
	logic         pend_fend;
	logic         pend_fstat;
	logic         host_byte;
	logic         take_ctrl;
	logic         take_arg;
	logic         proto_err;
	logic         soft_rst;
	logic         fwd;
	logic         g_confirm;
	logic         g_reset;
	logic         g_state;
	logic         g_config;
	logic         g_fend;
	logic         g_fstat;
	logic [4:0]   flags;
	logic [7:0]   config_byte;

	// ------------------------------------------------------------
	// command sorting
	// ------------------------------------------------------------
	cmd_decode u_decode
	(
		.ctrl     (host_rx_data),
		.svc      (svc),
		.extra    (extra),
		.transmit (transmit)
	);

	always_comb
	begin
		// corrupted bytes are dropped whole; the flag tells the host why
		host_byte = host_rx_valid && !host_rx_corrupt && control[CTL_HOST_EN];
		take_ctrl = host_byte && (state == ST_CTRL);
		take_arg  = host_byte && (state == ST_ARGS);
		proto_err = take_ctrl && (((svc == SVC_DATA_START) && in_frame) ||
			((svc == SVC_DATA_CONT || svc == SVC_DATA_END) && !in_frame)); // see RULE_15
		soft_rst  = take_ctrl && (svc == SVC_RESET);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state     <= ST_CTRL;
			args_left <= EXTRA_NONE;
			arg_kind  <= SVC_NONE;
			arg_tx    <= 1'b0;
		end
		else
		begin
			case (state)
				ST_CTRL:
				begin
					if (take_ctrl && extra != EXTRA_NONE) // see RULE_01
					begin
						state     <= ST_ARGS; // see RULE_02
						args_left <= extra;
						// a rejected command still swallows its data byte
						arg_kind  <= proto_err ? SVC_NONE : svc;
						arg_tx    <= transmit && !proto_err;
					end
				end
				ST_ARGS:
				begin
					if (take_arg)
					begin
						args_left <= args_left - 2'h1;
						if (args_left == EXTRA_ONE)
							state <= ST_CTRL;
					end
				end
				default: state <= ST_CTRL;
			endcase
		end
	end

	// ------------------------------------------------------------
	// bus transmit path
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			bus_tx_data  <= 8'h00;
			bus_tx_valid <= 1'b0;
			bus_tx_last  <= 1'b0;
			in_frame     <= 1'b0;
		end
		else
		begin
			bus_tx_valid <= take_arg && arg_tx; // see RULE_03
			bus_tx_last  <= take_arg && arg_tx && (arg_kind == SVC_DATA_END);
			if (take_arg && arg_tx)
				bus_tx_data <= host_rx_data;
			if (soft_rst)
				in_frame <= 1'b0;
			else if (take_ctrl && svc == SVC_DATA_START && !proto_err)
				in_frame <= 1'b1;
			else if (take_arg && arg_kind == SVC_DATA_END)
				in_frame <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// modes and features; busy mode also ends on acknowledge or quit busy, the rest only by reset service
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			auto_ack_flag  <= 1'b0;
			busy_mode      <= 1'b0;
			bus_monitor    <= 1'b0;
			auto_poll_flag <= 1'b0;
			crc_flag       <= 1'b0;
			marker_flag    <= 1'b0;
		end
		else if (soft_rst) // see RULE_11
		begin
			auto_ack_flag  <= 1'b0; // see RULE_23
			busy_mode      <= 1'b0;
			bus_monitor    <= 1'b0; // see RULE_22
			auto_poll_flag <= 1'b0;
			crc_flag       <= 1'b0;
			marker_flag    <= 1'b0;
		end
		else
		begin
			if (take_arg && arg_kind == SVC_SET_ADDR && args_left == EXTRA_ONE)
				auto_ack_flag <= 1'b1;
			if (take_ctrl && svc == SVC_SET_BUSY && auto_ack_flag) // see RULE_18
				busy_mode <= 1'b1;
			else if (take_ctrl && (svc == SVC_ACKN || svc == SVC_QUIT_BUSY))
				busy_mode <= 1'b0; // see RULE_19, RULE_20
			if (take_ctrl && svc == SVC_BUSMON)
				bus_monitor <= 1'b1; // see RULE_21
			// features only switch on; zeros merely ask for the status
			if (take_ctrl && svc == SVC_CONFIGURE)
			begin
				auto_poll_flag <= auto_poll_flag | host_rx_data[CFG_POLL_BIT];
				crc_flag       <= crc_flag | host_rx_data[CFG_CRC_BIT];
				marker_flag    <= marker_flag | host_rx_data[CFG_MARK_BIT];
			end
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			bus_ack_valid <= 1'b0;
			bus_ack_busy  <= 1'b0;
			device_reset  <= 1'b0;
		end
		else
		begin
			bus_ack_valid <= addressed_frame && auto_ack_flag;
			bus_ack_busy  <= addressed_frame && auto_ack_flag && busy_mode; // see RULE_17
			device_reset  <= soft_rst;
		end
	end

	// ------------------------------------------------------------
	// communication state flags
	// ------------------------------------------------------------
	event_flag u_sc
	(
		.clk        (clk),
		.reset      (reset),
		.soft_clear (soft_rst),
		.set        (poll_slot_collision), // see RULE_12
		.clear      (g_state), // see RULE_24
		.flag       (slave_collision_flag)
	);
	event_flag u_re
	(
		.clk        (clk),
		.reset      (reset),
		.soft_clear (soft_rst),
		.set        ((host_rx_valid && host_rx_corrupt) || tx_frame_bad ||
			(take_ctrl && svc == SVC_NONE)), // see RULE_13
		.clear      (g_state),
		.flag       (receive_error_flag)
	);
	event_flag u_te
	(
		.clk        (clk),
		.reset      (reset),
		.soft_clear (soft_rst),
		.set        (tx_active && tx_drive_dominant && bus_read_recessive), // see RULE_14
		.clear      (g_state),
		.flag       (transmit_error_flag)
	);
	event_flag u_pe
	(
		.clk        (clk),
		.reset      (reset),
		.soft_clear (soft_rst),
		.set        (proto_err), // see RULE_15
		.clear      (g_state),
		.flag       (protocol_error_flag)
	);
	event_flag u_tw
	(
		.clk        (clk),
		.reset      (reset),
		.soft_clear (soft_rst),
		.set        (thermal_warning), // see RULE_16
		.clear      (g_state),
		.flag       (thermal_warning_flag)
	);

	// ------------------------------------------------------------
	// indications to the host
	// ------------------------------------------------------------
	always_comb
	begin
		flags = {slave_collision_flag, receive_error_flag, transmit_error_flag,
			protocol_error_flag, thermal_warning_flag};
		config_byte = {1'b0, busy_mode, auto_ack_flag, auto_poll_flag, crc_flag,
			marker_flag, IND_CONFIG_LO}; // see RULE_08
		// bus bytes win the host line; indications wait in pending bits
		fwd       = bus_rx_valid && (!bus_rx_is_ack || bus_monitor); // see RULE_10, RULE_21
		g_confirm = !fwd && pend_confirm;
		g_reset   = !fwd && !pend_confirm && pend_reset;
		g_state   = !fwd && !pend_confirm && !pend_reset && pend_state;
		g_config  = !fwd && !pend_confirm && !pend_reset && !pend_state && pend_config;
		g_fend    = !fwd && !pend_confirm && !pend_reset && !pend_state && !pend_config &&
			pend_fend;
		g_fstat   = !fwd && !pend_confirm && !pend_reset && !pend_state && !pend_config &&
			!pend_fend && pend_fstat;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pend_confirm <= 1'b0;
			pend_reset   <= 1'b0;
			pend_state   <= 1'b0;
			pend_config  <= 1'b0;
			pend_fend    <= 1'b0;
			pend_fstat   <= 1'b0;
			confirm_ok   <= 1'b0;
			fstat_byte   <= 8'h00;
		end
		else
		begin
			if (tx_confirm_valid)
			begin
				pend_confirm <= 1'b1;
				confirm_ok   <= tx_confirm_ok;
			end
			else if (g_confirm)
				pend_confirm <= 1'b0;
			if (normal_entered)
				pend_reset <= 1'b1; // see RULE_11
			else if (g_reset)
				pend_reset <= 1'b0;
			if (take_ctrl && svc == SVC_STATE)
				pend_state <= 1'b1;
			else if (g_state)
				pend_state <= 1'b0;
			if ((take_ctrl && svc == SVC_CONFIGURE) ||
				(take_arg && arg_kind == SVC_SET_ADDR && args_left == EXTRA_ONE))
				pend_config <= 1'b1;
			else if (g_config)
				pend_config <= 1'b0;
			if (frame_done && marker_flag)
			begin
				pend_fend  <= 1'b1;
				pend_fstat <= 1'b1;
				fstat_byte <= {frame_parity_err, frame_cksum_err, frame_timing_err,
					IND_FSTAT_LO}; // see RULE_07
			end
			else
			begin
				if (g_fend)
					pend_fend <= 1'b0;
				if (g_fstat)
					pend_fstat <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			host_tx_data  <= 8'h00;
			host_tx_valid <= 1'b0;
		end
		else
		begin
			host_tx_valid <= fwd || g_confirm || g_reset || g_state || g_config ||
				g_fend || g_fstat;
			if (fwd)
				host_tx_data <= bus_rx_data; // see RULE_09, RULE_04
			else if (g_confirm)
				host_tx_data <= {confirm_ok, IND_CONFIRM_LO}; // see RULE_05
			else if (g_reset)
				host_tx_data <= IND_RESET;
			else if (g_state)
				host_tx_data <= {flags, IND_STATE_LO}; // see RULE_06
			else if (g_config)
				host_tx_data <= config_byte;
			else if (g_fend)
				host_tx_data <= IND_FRAME_END;
			else if (g_fstat)
				host_tx_data <= fstat_byte;
		end
	end

	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			control   <= CONTROL_RESET;
			reg_rdata <= 8'h00;
		end
		else
		begin
			if (reg_wr && reg_addr == REG_CONTROL)
				control <= reg_wdata;
			if (reg_rd)
			begin
				case (reg_addr)
					REG_CONTROL: reg_rdata <= control;
					REG_STATUS:  reg_rdata <= {flags, IND_STATE_LO};
					REG_CONFIG:  reg_rdata <= {bus_monitor, config_byte[6:2], 2'h0};
					default:     reg_rdata <= 8'h00;
				endcase
			end
			else
				reg_rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_mon_on;
		take_ctrl && svc == SVC_BUSMON ##1 bus_monitor;
	endsequence
	property p_single;
		@(posedge clk) disable iff (reset)
		take_ctrl && extra == EXTRA_NONE |=> state == ST_CTRL && !bus_tx_valid;
	endproperty
	a_single: assert property (p_single) else $error("single byte took args"); // see RULE_01
	property p_args;
		@(posedge clk) disable iff (reset)
		take_ctrl && extra == EXTRA_THREE |=> state == ST_ARGS && args_left == EXTRA_THREE;
	endproperty
	a_args: assert property (p_args) else $error("multi byte args lost"); // see RULE_02
	property p_internal;
		@(posedge clk) disable iff (reset)
		take_arg && !arg_tx |=> !bus_tx_valid;
	endproperty
	a_internal: assert property (p_internal) else $error("internal cmd hit bus"); // see RULE_03
	property p_confirm;
		@(posedge clk) disable iff (reset)
		g_confirm |=> host_tx_valid && host_tx_data == {$past(confirm_ok), IND_CONFIRM_LO};
	endproperty
	a_confirm: assert property (p_confirm) else $error("bad confirm byte"); // see RULE_05
	property p_state;
		@(posedge clk) disable iff (reset)
		g_state |=> host_tx_data == {$past(flags), IND_STATE_LO} && host_tx_valid;
	endproperty
	a_state: assert property (p_state) else $error("bad state byte"); // see RULE_06
	property p_forward;
		@(posedge clk) disable iff (reset)
		fwd |=> host_tx_valid && host_tx_data == $past(bus_rx_data);
	endproperty
	a_forward: assert property (p_forward) else $error("bus byte altered"); // see RULE_09
	property p_ack_drop;
		@(posedge clk) disable iff (reset)
		bus_rx_valid && bus_rx_is_ack && !bus_monitor && !pend_confirm && !pend_reset &&
			!pend_state && !pend_config && !pend_fend && !pend_fstat |=> !host_tx_valid;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack byte leaked"); // see RULE_10
	property p_busy_ack;
		@(posedge clk) disable iff (reset)
		addressed_frame && auto_ack_flag && busy_mode |=> bus_ack_valid && bus_ack_busy;
	endproperty
	a_busy_ack: assert property (p_busy_ack) else $error("no busy ack"); // see RULE_17
	property p_busy_noop;
		@(posedge clk) disable iff (reset)
		take_ctrl && svc == SVC_SET_BUSY && !auto_ack_flag |=> !busy_mode;
	endproperty
	a_busy_noop: assert property (p_busy_noop) else $error("busy without ack"); // see RULE_18
	property p_monitor;
		@(posedge clk) disable iff (reset)
		s_mon_on ##0 !soft_rst [*4] |-> bus_monitor;
	endproperty
	a_monitor: assert property (p_monitor) else $error("monitor left early"); // see RULE_22
endmodule
`default_nettype wire

// ==== design/link_ctl_pkg.sv ====
// constants and types shared by the host service link control block
`default_nettype none
package link_ctl_pkg;
	// ------------------------------------------------------------
	// host command codes and code ranges
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_RESET      = 8'h01;
	localparam logic [7:0] CMD_STATE      = 8'h02;
	localparam logic [7:0] CMD_SET_BUSY   = 8'h03;
	localparam logic [7:0] CMD_QUIT_BUSY  = 8'h04;
	localparam logic [7:0] CMD_BUSMON     = 8'h05;
	localparam logic [7:0] CMD_SYS_STATE  = 8'h0d;
	localparam logic [7:0] CMD_STOP       = 8'h0e;
	localparam logic [7:0] CMD_EXIT_STOP  = 8'h0f;
	localparam logic [7:0] CMD_SET_ADDR   = 8'hf1;
	localparam logic [7:0] CMD_SET_REP    = 8'hf2;
	localparam logic [7:0] CMD_DATA_START = 8'h80;
	localparam logic [7:0] CMD_OFFSET_LO  = 8'h08;
	localparam logic [7:0] CMD_OFFSET_HI  = 8'h0c;
	localparam logic [7:0] CMD_END_LO     = 8'h47;
	localparam logic [7:0] CMD_POLL_HI    = 8'hee;
	localparam logic [7:0] MASK_OCT       = 8'hf8;
	localparam logic [7:0] MASK_QUAD      = 8'hfc;
	localparam logic [7:0] MASK_TOP2      = 8'hc0;
	localparam logic [7:0] MASK_TOP4      = 8'hf0;
	localparam logic [7:0] CMD_ACKN       = 8'h10;
	localparam logic [7:0] CMD_CONFIGURE  = 8'h18;
	localparam logic [7:0] CMD_REG_WR     = 8'h28;
	localparam logic [7:0] CMD_REG_RD     = 8'h38;
	localparam logic [7:0] CMD_POLL       = 8'he0;
	localparam logic [7:0] CMD_TOP_CONT   = 8'h80;
	localparam logic [7:0] CMD_TOP_END    = 8'h40;
	localparam logic [1:0] EXTRA_NONE     = 2'h0;
	localparam logic [1:0] EXTRA_ONE      = 2'h1;
	localparam logic [1:0] EXTRA_THREE    = 2'h3;
	// configure request feature bit positions
	localparam int CFG_POLL_BIT = 2;
	localparam int CFG_CRC_BIT  = 1;
	localparam int CFG_MARK_BIT = 0;
	// ------------------------------------------------------------
	// indication bytes to the host
	// ------------------------------------------------------------
	localparam logic [7:0] IND_RESET      = 8'h03;
	localparam logic [6:0] IND_CONFIRM_LO = 7'h0b;
	localparam logic [2:0] IND_STATE_LO   = 3'h7;
	localparam logic [4:0] IND_FSTAT_LO   = 5'h13;
	localparam logic [1:0] IND_CONFIG_LO  = 2'h1;
	localparam logic [7:0] IND_FRAME_END  = 8'hcb;
	// ------------------------------------------------------------
	// register port map
	// ------------------------------------------------------------
	localparam logic [3:0] REG_CONTROL    = 4'h0;
	localparam logic [3:0] REG_STATUS     = 4'h4;
	localparam logic [3:0] REG_CONFIG     = 4'h8;
	localparam logic [7:0] CONTROL_RESET  = 8'h01;
	localparam int         CTL_HOST_EN    = 0;
	typedef enum logic [4:0] {
		SVC_NONE, SVC_RESET, SVC_STATE, SVC_SET_BUSY, SVC_QUIT_BUSY, SVC_BUSMON,
		SVC_SET_ADDR, SVC_SET_REP, SVC_OFFSET, SVC_SYS_STATE, SVC_STOP, SVC_EXIT_STOP,
		SVC_ACKN, SVC_CONFIGURE, SVC_REG_WR, SVC_REG_RD, SVC_POLL,
		SVC_DATA_START, SVC_DATA_CONT, SVC_DATA_END
	} svc_t;
	typedef enum logic [1:0] {
		ST_CTRL = 2'b01,
		ST_ARGS = 2'b10
	} parse_state_t;
endpackage
`default_nettype wire
